// ### ier_router.sv
// Interrupt enable and pin routing block with its register slice
`default_nettype none

module ier_router #(
  parameter int unsigned NSRC = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Internal register port
  input wire logic [ier_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [ier_pkg::REG_DW-1:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [ier_pkg::REG_DW-1:0] o_reg_rdata,
  // Event flags from the detectors, one per enable bit position
  input wire logic [NSRC-1:0] i_src_event,
  // Pin configuration from the control register next door
  input wire logic i_irq_polarity,
  input wire logic i_open_drain,
  // Interrupt pins
  output logic o_irq_pin_a,
  output logic o_irq_pin_a_oe,
  output logic o_irq_pin_b,
  output logic o_irq_pin_b_oe
);

  typedef struct packed {
    logic [NSRC-1:0] source_enable;
    logic [NSRC-1:0] pin_routing;
    logic [ier_pkg::REG_DW-1:0] rdata;
  } ier_state_t;

  ier_state_t state_reg;
  ier_state_t state_next;

  logic [NSRC-1:0] gated;
  logic [NSRC-1:0] to_pin_a;
  logic [NSRC-1:0] to_pin_b;
  logic active_a;
  logic active_b;

  // Source gating and steering
  always_comb begin
    gated = i_src_event & state_reg.source_enable & ier_pkg::FIELD_MASK; // RL1 RL2
    to_pin_a = gated & state_reg.pin_routing; // RL4
    to_pin_b = gated & ~state_reg.pin_routing; // RL4
  end

  // Register writes and reads
  always_comb begin
    state_next = state_reg;
    if (i_reg_wr && (i_reg_addr == ier_pkg::SOURCE_ENABLE_ADDR)) begin
      state_next.source_enable = i_reg_wdata & ier_pkg::FIELD_MASK; // RL3
    end
    if (i_reg_wr && (i_reg_addr == ier_pkg::PIN_ROUTING_ADDR)) begin
      state_next.pin_routing = i_reg_wdata & ier_pkg::FIELD_MASK; // RL6
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        ier_pkg::SOURCE_ENABLE_ADDR: begin
          state_next.rdata = state_reg.source_enable & ier_pkg::FIELD_MASK; // RL3
        end
        ier_pkg::PIN_ROUTING_ADDR: begin
          state_next.rdata = state_reg.pin_routing & ier_pkg::FIELD_MASK; // RL6
        end
        ier_pkg::IRQ_STATUS_ADDR: begin
          state_next.rdata = gated; // RL8
        end
        default: begin
          state_next.rdata = ier_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg.source_enable <= ier_pkg::SOURCE_ENABLE_RST; // RL1
      state_reg.pin_routing <= ier_pkg::PIN_ROUTING_RST; // RL5
      state_reg.rdata <= ier_pkg::READ_DATA_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_reg_rdata = state_reg.rdata;

  // Pin A takes sources whose routing bit is one
  ier_pin_drive #(
    .NSRC(NSRC)
  ) u_pin_a (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_flags(to_pin_a),
    .i_irq_polarity(i_irq_polarity),
    .i_open_drain(i_open_drain),
    .o_pin(o_irq_pin_a),
    .o_pin_oe(o_irq_pin_a_oe),
    .o_active(active_a)
  );

  // Pin B takes sources whose routing bit is zero
  ier_pin_drive #(
    .NSRC(NSRC)
  ) u_pin_b (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_flags(to_pin_b),
    .i_irq_polarity(i_irq_polarity),
    .i_open_drain(i_open_drain),
    .o_pin(o_irq_pin_b),
    .o_pin_oe(o_irq_pin_b_oe),
    .o_active(active_b)
  );

  // Checks
  chk_enable_write: assert property ( // RL1
    @(posedge i_core_clk) disable iff (i_rst)
    (i_reg_wr && (i_reg_addr == ier_pkg::SOURCE_ENABLE_ADDR))
    |=> (state_reg.source_enable == ($past(i_reg_wdata) & ier_pkg::FIELD_MASK)))
    else $error("source enable not updated by write");

  chk_disabled_blocked: assert property ( // RL2
    @(posedge i_core_clk) disable iff (i_rst)
    ((|(i_src_event & ~state_reg.source_enable)) && !(|to_pin_a) && !(|to_pin_b))
    |=> (!active_a && !active_b) [*1])
    else $error("disabled source reached a pin");

  chk_bit1_zero: assert property ( // RL3 RL6
    @(posedge i_core_clk) disable iff (i_rst)
    !state_reg.source_enable[1] && !state_reg.pin_routing[1] && !gated[1])
    else $error("bit 1 of enable or routing is set");

  chk_route_a: assert property ( // RL4 RL7
    @(posedge i_core_clk) disable iff (i_rst)
    (|(i_src_event & state_reg.source_enable & state_reg.pin_routing & 8'hFD))
    |=> (o_irq_pin_a == $past(i_irq_polarity)))
    else $error("routed source did not assert pin A");

  chk_route_b: assert property ( // RL4 RL7
    @(posedge i_core_clk) disable iff (i_rst)
    (|(i_src_event & state_reg.source_enable & ~state_reg.pin_routing & 8'hFD))
    |=> (o_irq_pin_b == $past(i_irq_polarity)))
    else $error("routed source did not assert pin B");

  chk_routing_reset: assert property ( // RL5
    @(posedge i_core_clk)
    $fell(i_rst) |-> (state_reg.pin_routing == 8'h00) && (state_reg.source_enable == 8'h00))
    else $error("routing or enable not zero after reset");

  chk_polarity_low: assert property ( // RL9
    @(posedge i_core_clk) disable iff (i_rst)
    (active_a && (i_irq_polarity == ier_pkg::POL_ACTIVE_LOW) && $stable(i_irq_polarity))
    |-> (o_irq_pin_a == 1'b0))
    else $error("pin A not active low");

  chk_release_a: assert property ( // RL10
    @(posedge i_core_clk) disable iff (i_rst)
    $fell(|to_pin_a) |=> (o_irq_pin_a == !$past(i_irq_polarity)) && !active_a)
    else $error("pin A did not release");

  chk_release_b: assert property ( // RL10
    @(posedge i_core_clk) disable iff (i_rst)
    !(|to_pin_b) ##1 !(|to_pin_b) |-> (o_irq_pin_b == !$past(i_irq_polarity)))
    else $error("pin B did not release");

  chk_status_read: assert property ( // RL8
    @(posedge i_core_clk) disable iff (i_rst)
    (i_reg_rd && (i_reg_addr == ier_pkg::IRQ_STATUS_ADDR))
    |=> (o_reg_rdata == $past(gated)))
    else $error("status read does not show gated flags");

  chk_routing_write: assert property ( // RL6
    @(posedge i_core_clk) disable iff (i_rst)
    (i_reg_wr && (i_reg_addr == ier_pkg::PIN_ROUTING_ADDR))
    |=> (state_reg.pin_routing == ($past(i_reg_wdata) & ier_pkg::FIELD_MASK)))
    else $error("pin routing not updated by write");

  chk_enable_hold: assert property ( // RL1
    @(posedge i_core_clk) disable iff (i_rst)
    !(i_reg_wr && (i_reg_addr == ier_pkg::SOURCE_ENABLE_ADDR))
    |=> $stable(state_reg.source_enable))
    else $error("source enable changed without a write");

  chk_routing_hold: assert property ( // RL5
    @(posedge i_core_clk) disable iff (i_rst)
    !(i_reg_wr && (i_reg_addr == ier_pkg::PIN_ROUTING_ADDR))
    |=> $stable(state_reg.pin_routing))
    else $error("pin routing changed without a write");

  chk_raise_a: assert property ( // RL7
    @(posedge i_core_clk) disable iff (i_rst)
    (|to_pin_a) |=> active_a)
    else $error("pin A not active for a routed flag");

  chk_raise_b: assert property ( // RL7
    @(posedge i_core_clk) disable iff (i_rst)
    (|to_pin_b) |=> active_b)
    else $error("pin B not active for a routed flag");

  chk_polarity_high: assert property ( // RL9
    @(posedge i_core_clk) disable iff (i_rst)
    (active_b && (i_irq_polarity == ier_pkg::POL_ACTIVE_HIGH) && $stable(i_irq_polarity))
    |-> (o_irq_pin_b == 1'b1))
    else $error("pin B not active high");

  chk_polarity_low_b: assert property ( // RL9
    @(posedge i_core_clk) disable iff (i_rst)
    (active_b && (i_irq_polarity == ier_pkg::POL_ACTIVE_LOW) && $stable(i_irq_polarity))
    |-> (o_irq_pin_b == 1'b0))
    else $error("pin B not active low");

  chk_status_gated: assert property ( // RL2
    @(posedge i_core_clk) disable iff (i_rst)
    (i_reg_rd && (i_reg_addr == ier_pkg::IRQ_STATUS_ADDR))
    |=> ((o_reg_rdata & ~$past(state_reg.source_enable)) == 8'h00))
    else $error("status shows a disabled source");

endmodule : ier_router

`default_nettype wire

// ### ier_pkg.sv
// Package with register map, field layout and reset values for the interrupt enable router
// How it works
// RL1: A cleared enable bit blocks its source; all enables reset cleared.
// RL2: Only flags of enabled sources reach the pin logic.
// RL3: Enable bits: 7 sleep/wake, 6 FIFO, 5 transient, 4 orientation, 3 pulse, 2 fall, 0 ready.
// RL4: Routing bit zero steers a source to pin B, one to pin A.
// RL5: All routing bits reset to zero, so every source starts on pin B.
// RL6: Routing register uses the enable bit positions; bit 1 reads zero.
// RL7: A pin is active while any enabled source routed to it signals.
// RL8: Host reads the interrupt status register to learn which sources are pending.
// RL9: Pins are active low when polarity is zero, active high when one.
// RL10: A pin goes inactive once no enabled routed source still has a flag.
`default_nettype none

package ier_pkg;

  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 8;

  // Register offsets
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0C;
  localparam logic [7:0] SOURCE_ENABLE_ADDR = 8'h2D;
  localparam logic [7:0] PIN_ROUTING_ADDR = 8'h2E;

  // Field positions, shared by enable, routing and status
  localparam int unsigned SLEEP_WAKE_BIT = 7;
  localparam int unsigned FIFO_BIT = 6;
  localparam int unsigned TRANSIENT_BIT = 5;
  localparam int unsigned ORIENTATION_BIT = 4;
  localparam int unsigned PULSE_BIT = 3;
  localparam int unsigned FALL_MOTION_BIT = 2;
  localparam int unsigned SAMPLE_READY_BIT = 0;

  // Implemented bits; bit 1 always reads zero
  localparam logic [7:0] FIELD_MASK = 8'hFD;

  // Reset values
  localparam logic [7:0] SOURCE_ENABLE_RST = 8'h00;
  localparam logic [7:0] PIN_ROUTING_RST = 8'h00;
  localparam logic [7:0] READ_DATA_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Polarity select values
  localparam logic POL_ACTIVE_LOW = 1'b0;
  localparam logic POL_ACTIVE_HIGH = 1'b1;

endpackage : ier_pkg

`default_nettype wire

// ### ier_pin_drive.sv
// One interrupt pin driver: merges routed flags and applies polarity and drive mode
`default_nettype none

module ier_pin_drive #(
  parameter int unsigned NSRC = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Flags already gated and routed to this pin
  input wire logic [NSRC-1:0] i_flags,
  // Pin configuration
  input wire logic i_irq_polarity,
  input wire logic i_open_drain,
  // Pin
  output logic o_pin,
  output logic o_pin_oe,
  output logic o_active
);

  typedef struct packed {
    logic active;
    logic level;
    logic oe;
  } ier_pin_state_t;

  ier_pin_state_t state_reg;
  ier_pin_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.active = |i_flags; // RL7 RL10
    state_next.level = (i_irq_polarity == ier_pkg::POL_ACTIVE_HIGH) ?
                       state_next.active : ~state_next.active; // RL9
    // Out of reset, open drain only pulls low; reset drives high in both modes; push-pull always drives
    state_next.oe = i_open_drain ? ~state_next.level : 1'b1;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '{active: 1'b0, level: 1'b1, oe: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_pin = state_reg.level;
  assign o_pin_oe = state_reg.oe;
  assign o_active = state_reg.active;

endmodule : ier_pin_drive

`default_nettype wire

// ### ier_host_model.sv
// Host side model: resolves the two interrupt wires and decodes their active state
`default_nettype none

module ier_host_model (
  // Pins from the device
  input wire logic i_pin_a,
  input wire logic i_pin_a_oe,
  input wire logic i_pin_b,
  input wire logic i_pin_b_oe,
  // Polarity the host was set up for
  input wire logic i_irq_polarity,
  // Decoded interrupt requests
  output logic o_seen_a,
  output logic o_seen_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wire_a;
  logic wire_b;
  // Board pull-up holds a released wire high
  assign wire_a = i_pin_a_oe ? i_pin_a : 1'b1;
  assign wire_b = i_pin_b_oe ? i_pin_b : 1'b1;
  assign o_seen_a = (wire_a == i_irq_polarity);
  assign o_seen_b = (wire_b == i_irq_polarity);
endmodule : ier_host_model

`default_nettype wire

// ### ier_router_test.sv
// Testbench for the interrupt enable router
`default_nettype none

module ier_router_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pol = 1'b0;
  logic od = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] ev = 8'h00;
  logic [7:0] rdat;
  logic pa, pa_oe, pb, pb_oe, sa, sb;
  int err_count = 0;
  int checks_done = 0;

  always #20 clk = ~clk;

  ier_router u_ier_router (.i_core_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_src_event(ev),
    .i_irq_polarity(pol), .i_open_drain(od), .o_irq_pin_a(pa), .o_irq_pin_a_oe(pa_oe),
    .o_irq_pin_b(pb), .o_irq_pin_b_oe(pb_oe));
  ier_host_model u_ier_host_model (.i_pin_a(pa), .i_pin_a_oe(pa_oe), .i_pin_b(pb),
    .i_pin_b_oe(pb_oe), .i_irq_polarity(pol), .o_seen_a(sa), .o_seen_b(sb));

  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
    addr = ad;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_reg

  task automatic chk_reg(input logic [7:0] ad, input logic [7:0] e);
    addr = ad;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    cmp("read data", e, rdat);
    @(negedge clk);
  endtask : chk_reg

  task automatic route(input logic [7:0] en, rt, e, input logic p, o);
    logic ea, eb;
    wr_reg(8'h2D, en);
    wr_reg(8'h2E, rt);
    ev = e;
    pol = p;
    od = o;
    ea = |(e & en & rt & 8'hFD);
    eb = |(e & en & ~rt & 8'hFD);
    repeat (2) @(negedge clk);
    cmp("host seen", {6'h00, ea, eb}, {6'h00, sa, sb});
    cmp("pin levels", {6'h00, ~(ea ^ p), ~(eb ^ p)}, {6'h00, pa, pb});
    if (o) cmp("pin enables", {6'h00, ea ^ p, eb ^ p}, {6'h00, pa_oe, pb_oe});
    else cmp("pin enables", 8'h03, {6'h00, pa_oe, pb_oe});
    chk_reg(8'h0C, e & en & 8'hFD);
    ev = 8'h00;
    @(negedge clk);
    cmp("host idle", 8'h00, {6'h00, sa, sb});
  endtask : route

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    #1ms;
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    ev = 8'hFF;
    chk_reg(8'h2D, 8'h00);
    chk_reg(8'h2E, 8'h00);
    cmp("host seen", 8'h00, {6'h00, sa, sb});
    $display("test reset values done");
    wr_reg(8'h2D, 8'hFF);
    chk_reg(8'h2D, 8'hFD);
    wr_reg(8'h2E, 8'hFF);
    chk_reg(8'h2E, 8'hFD);
    chk_reg(8'h2F, 8'h00);
    $display("test register map done");
    for (int i = 0; i < 8; i++) begin
      route(8'h01 << i, 8'h00, 8'h01 << i, 1'b0, 1'b0);
      route(8'hFF, 8'h01 << i, 8'h01 << i, 1'b1, 1'b0);
      route(~(8'h01 << i), 8'hAA, 8'h01 << i, 1'b0, 1'b1);
    end
    $display("test per source routing done");
    route(8'hFD, 8'h0F, 8'hF5, 1'b0, 1'b0);
    route(8'hFD, 8'h0F, 8'h04, 1'b1, 1'b0);
    for (int m = 0; m < 4; m++) begin
      route(8'h85, 8'h81, 8'h84, m[0], m[1]);
      route(8'h85, 8'h81, 8'h01, m[0], m[1]);
    end
    $display("test sharing and polarity done");
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_reg(8'h2D, 8'h00);
    chk_reg(8'h2E, 8'h00);
    cmp("host seen", 8'h00, {6'h00, sa, sb});
    $display("test second reset done");
    give_verdict();
  end
endmodule : ier_router_test

`default_nettype wire
